// file: design/sbx_cfg.svh
// Constants for the secondary bus 64-bit extension ends.
// Assumes both ends share one secondary bus clock.
`ifndef SBX_CFG_SVH
`define SBX_CFG_SVH

// Cycles after address phase the master waits for target select
`define SBX_DEVSEL_WAIT 3'h5
// Extra decode cycles the far-end target takes before selecting
`define SBX_TGT_DLY     2'h1
// Command bit that marks a write command
`define SBX_CMD_WR_BIT  0
// Value shown on lanes whose content is undefined
`define SBX_AD_IDLE     32'h0000_0000
`define SBX_CBE_IDLE    4'h0

`endif

// file: design/sbx_pkg.sv
// Types and shared parity function for the 64-bit extension.
// Assumes sbx_cfg.svh holds the numeric constants.
package sbx_pkg;

  // Device (master) sequencer, Gray along the usual path
  typedef enum logic [2:0] {
    SBX_M_IDLE = 3'b000,
    SBX_M_ADDR = 3'b001,
    SBX_M_WAIT = 3'b011,
    SBX_M_TURN = 3'b010
  } sbx_mst_t;

  // Far-end target sequencer
  typedef enum logic [1:0] {
    SBX_T_IDLE = 2'b00,
    SBX_T_DEC  = 2'b01,
    SBX_T_DATA = 2'b11,
    SBX_T_REL  = 2'b10
  } sbx_tgt_t;

  // Even parity over upper lanes and upper command/enables
  function automatic logic sbx_par_even(input logic [31:0] ad,
                                        input logic [3:0]  cbe);
    sbx_par_even = ^{ad, cbe};
  endfunction : sbx_par_even

endpackage : sbx_pkg

// file: design/sbx_bus_if.sv
// Secondary bus upper-lane wires joining the bridge end and a target.
// Assumes each driver turns its enable off before the other turns on.
`timescale 1ns/1ps
`include "sbx_cfg.svh"
interface sbx_bus_if;
  logic        m_frame_o;
  logic        m_frame_oe;
  logic        m_req64_o;
  logic        m_req64_oe;
  logic [3:0]  m_cbe_o;
  logic        m_cbe_oe;
  logic [31:0] m_ad_o;
  logic        m_ad_oe;
  logic        m_par_o;
  logic        m_par_oe;
  logic [31:0] t_ad_o;
  logic        t_ad_oe;
  logic        t_par_o;
  logic        t_par_oe;
  logic        t_devsel_o;
  logic        t_devsel_oe;
  logic        t_ack64_o;
  logic        t_ack64_oe;
  wire         frame_n;
  wire         sec_wide_request_n;
  wire  [3:0]  sec_upper_cmd_byte_en;
  wire  [31:0] ad_hi;
  wire         sec_upper_parity;
  wire         sec_target_select_n;
  wire         sec_wide_ack_n;

  // Released control lines float high through pull-ups; released lanes, enables and parity read as zero
  assign frame_n             = m_frame_oe ? m_frame_o : 1'b1;
  assign sec_wide_request_n  = m_req64_oe ? m_req64_o : 1'b1;
  assign sec_target_select_n = t_devsel_oe ? t_devsel_o : 1'b1;
  assign sec_wide_ack_n      = t_ack64_oe ? t_ack64_o : 1'b1;
  assign sec_upper_cmd_byte_en = m_cbe_oe ? m_cbe_o : `SBX_CBE_IDLE;
  assign ad_hi = m_ad_oe ? m_ad_o : (t_ad_oe ? t_ad_o : `SBX_AD_IDLE);
  assign sec_upper_parity = m_par_oe ? m_par_o : (t_par_oe & t_par_o);

  modport dev (
    output m_frame_o, m_frame_oe, m_req64_o, m_req64_oe, m_cbe_o, m_cbe_oe,
    output m_ad_o, m_ad_oe, m_par_o, m_par_oe,
    input  frame_n, sec_wide_request_n, sec_upper_cmd_byte_en, ad_hi,
    input  sec_upper_parity, sec_target_select_n, sec_wide_ack_n
  );

  modport tgt (
    output t_ad_o, t_ad_oe, t_par_o, t_par_oe,
    output t_devsel_o, t_devsel_oe, t_ack64_o, t_ack64_oe,
    input  frame_n, sec_wide_request_n, sec_upper_cmd_byte_en, ad_hi,
    input  sec_upper_parity, sec_target_select_n, sec_wide_ack_n
  );
endinterface : sbx_bus_if

// file: design/sbx_dev_end.sv
// Bridge-side master end of the secondary bus 64-bit extension.
// Assumes bus and user side share clk; one data phase per request.
`timescale 1ns/1ps
`include "sbx_cfg.svh"

module sbx_dev_end (
  input  wire logic        clk,
  input  wire logic        srst,
  sbx_bus_if.dev           bus,
  input  wire logic        start,
  input  wire logic        dac,
  input  wire logic        wide_master,
  input  wire logic        force_wide_transfer,
  input  wire logic [3:0]  cmd,
  input  wire logic [31:0] addr_hi,
  input  wire logic [31:0] wdata_hi,
  input  wire logic [3:0]  be_hi,
  output logic             busy_r,
  output logic             done_r,
  output logic             abort_r,
  output logic             wide_done_r,
  output logic [31:0]      rdata_hi_r,
  output logic             par_err_r,
  output logic             peer_wide_r
);

  sbx_pkg::sbx_mst_t st_r;
  sbx_pkg::sbx_mst_t st_nxt;
  logic [2:0]  cnt_r,      cnt_nxt;
  logic        req_w_r,    req_w_nxt;
  logic        ack_w_r,    ack_w_nxt;
  logic        wr_r,       wr_nxt;
  logic [31:0] wd_r,       wd_nxt;
  logic [3:0]  be_r,       be_nxt;
  logic        busy_nxt;
  logic        done_nxt;
  logic        abort_nxt;
  logic        wide_done_nxt;
  logic [31:0] rdata_hi_nxt;
  logic        par_err_nxt;
  logic        peer_wide_nxt;
  logic        frame_o_r,  frame_o_nxt;
  logic        frame_oe_r, frame_oe_nxt;
  logic        req_o_r,    req_o_nxt;
  logic        req_oe_r,   req_oe_nxt;
  logic [3:0]  cbe_o_r,    cbe_o_nxt;
  logic        cbe_oe_r,   cbe_oe_nxt;
  logic [31:0] ad_o_r,     ad_o_nxt;
  logic        ad_oe_r,    ad_oe_nxt;
  logic        par_o_r,    par_o_nxt;
  logic        par_oe_r,   par_oe_nxt;

  // Pins come straight from the output flops
  assign bus.m_frame_o  = frame_o_r;
  assign bus.m_frame_oe = frame_oe_r;
  assign bus.m_req64_o  = req_o_r;
  assign bus.m_req64_oe = req_oe_r;
  assign bus.m_cbe_o    = cbe_o_r;
  assign bus.m_cbe_oe   = cbe_oe_r;
  assign bus.m_ad_o     = ad_o_r;
  assign bus.m_ad_oe    = ad_oe_r;
  assign bus.m_par_o    = par_o_r;
  assign bus.m_par_oe   = par_oe_r;

  // Master sequencer: address, wait for select, turnaround
  always_comb begin
    st_nxt        = st_r;
    cnt_nxt       = cnt_r;
    req_w_nxt     = req_w_r;
    ack_w_nxt     = ack_w_r;
    wr_nxt        = wr_r;
    wd_nxt        = wd_r;
    be_nxt        = be_r;
    busy_nxt      = busy_r;
    done_nxt      = 1'b0;
    abort_nxt     = 1'b0;
    wide_done_nxt = wide_done_r;
    rdata_hi_nxt  = rdata_hi_r;
    par_err_nxt   = 1'b0;
    frame_o_nxt   = frame_o_r;
    frame_oe_nxt  = frame_oe_r;
    req_o_nxt     = req_o_r;
    req_oe_nxt    = req_oe_r;
    cbe_o_nxt     = cbe_o_r;
    cbe_oe_nxt    = cbe_oe_r;
    ad_o_nxt      = ad_o_r;
    ad_oe_nxt     = ad_oe_r;
    par_o_nxt     = par_o_r;
    par_oe_nxt    = par_oe_r;
    unique case (st_r)
      sbx_pkg::SBX_M_IDLE: begin
        if (start) begin
          st_nxt       = sbx_pkg::SBX_M_ADDR;
          busy_nxt     = 1'b1;
          wide_done_nxt = 1'b0;
          req_w_nxt    = wide_master | force_wide_transfer;
          req_o_nxt    = ~(wide_master | force_wide_transfer);
          req_oe_nxt   = 1'b1;
          frame_o_nxt  = 1'b0;
          frame_oe_nxt = 1'b1;
          wr_nxt       = cmd[`SBX_CMD_WR_BIT];
          wd_nxt       = wdata_hi;
          be_nxt       = be_hi;
          // upper address only on wide DAC
          ad_o_nxt     = (dac & (wide_master | force_wide_transfer)) ?
                         addr_hi : `SBX_AD_IDLE;
          ad_oe_nxt    = 1'b1;
          // real command only on wide DAC
          cbe_o_nxt    = (dac & (wide_master | force_wide_transfer)) ?
                         cmd : `SBX_CBE_IDLE;
          cbe_oe_nxt   = 1'b1;
        end
      end
      sbx_pkg::SBX_M_ADDR: begin
        st_nxt      = sbx_pkg::SBX_M_WAIT;
        cnt_nxt     = 3'h0;
        // Single data phase: frame and wide request end here
        frame_o_nxt = 1'b1;
        req_o_nxt   = 1'b1;
        par_o_nxt   = sbx_pkg::sbx_par_even(ad_o_r, cbe_o_r);
        par_oe_nxt  = req_w_r;
        // upper enables for the wide data phase
        cbe_o_nxt   = req_w_r ? be_r : `SBX_CBE_IDLE;
        cbe_oe_nxt  = req_w_r;
        // upper write word only if wide requested
        ad_o_nxt    = (wr_r & req_w_r) ? wd_r : `SBX_AD_IDLE;
        ad_oe_nxt   = wr_r & req_w_r;
      end
      sbx_pkg::SBX_M_WAIT: begin
        cnt_nxt = cnt_r + 3'h1;
        // Deasserted-high cycle done, hand lines back
        if (cnt_r == 3'h0) begin
          frame_oe_nxt = 1'b0;
          req_oe_nxt   = 1'b0;
          par_oe_nxt   = 1'b0;
        end
        if (!bus.sec_target_select_n) begin
          st_nxt = sbx_pkg::SBX_M_TURN;
          done_nxt = 1'b1;
          // upper lanes count only with wide ack
          ack_w_nxt     = req_w_r & ~bus.sec_wide_ack_n;
          wide_done_nxt = req_w_r & ~bus.sec_wide_ack_n;
          if (!wr_r && req_w_r && !bus.sec_wide_ack_n) begin
            rdata_hi_nxt = bus.ad_hi;
          end
          // write data parity one clock after data
          par_o_nxt  = sbx_pkg::sbx_par_even(ad_o_r, cbe_o_r);
          par_oe_nxt = wr_r & req_w_r & ~bus.sec_wide_ack_n;
          ad_oe_nxt  = 1'b0;
          cbe_oe_nxt = 1'b0;
        end else if (cnt_r == `SBX_DEVSEL_WAIT - 3'h1) begin
          st_nxt     = sbx_pkg::SBX_M_TURN;
          abort_nxt  = 1'b1;
          ack_w_nxt  = 1'b0;
          ad_oe_nxt  = 1'b0;
          cbe_oe_nxt = 1'b0;
        end
      end
      sbx_pkg::SBX_M_TURN: begin
        st_nxt     = sbx_pkg::SBX_M_IDLE;
        busy_nxt   = 1'b0;
        par_oe_nxt = 1'b0;
        // read parity checked only on wide ack
        par_err_nxt = ack_w_r & ~wr_r &
          (bus.sec_upper_parity !=
           sbx_pkg::sbx_par_even(rdata_hi_r, be_r));
      end
      default: begin
        st_nxt = sbx_pkg::SBX_M_IDLE;
      end
    endcase
  end

  // Wide request from other masters, seen only while idle
  always_comb begin
    peer_wide_nxt = peer_wide_r;
    // other master marks its frame as wide
    if (st_r == sbx_pkg::SBX_M_IDLE && !bus.frame_n && !frame_oe_r) begin
      peer_wide_nxt = ~bus.sec_wide_request_n;
    end
    // reset masks the wide request input
    if (srst) begin
      peer_wide_nxt = 1'b0;
    end
  end

  // State and pin registers, all released in reset
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r        <= sbx_pkg::SBX_M_IDLE;
      cnt_r       <= 3'h0;
      req_w_r     <= 1'b0;
      ack_w_r     <= 1'b0;
      wr_r        <= 1'b0;
      wd_r        <= 32'h0000_0000;
      be_r        <= 4'h0;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      abort_r     <= 1'b0;
      wide_done_r <= 1'b0;
      rdata_hi_r  <= 32'h0000_0000;
      par_err_r   <= 1'b0;
      frame_o_r   <= 1'b1;
      frame_oe_r  <= 1'b0;
      req_o_r     <= 1'b1;
      req_oe_r    <= 1'b0;
      cbe_o_r     <= 4'h0;
      cbe_oe_r    <= 1'b0;
      ad_o_r      <= 32'h0000_0000;
      ad_oe_r     <= 1'b0;
      par_o_r     <= 1'b0;
      par_oe_r    <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      cnt_r       <= cnt_nxt;
      req_w_r     <= req_w_nxt;
      ack_w_r     <= ack_w_nxt;
      wr_r        <= wr_nxt;
      wd_r        <= wd_nxt;
      be_r        <= be_nxt;
      busy_r      <= busy_nxt;
      done_r      <= done_nxt;
      abort_r     <= abort_nxt;
      wide_done_r <= wide_done_nxt;
      rdata_hi_r  <= rdata_hi_nxt;
      par_err_r   <= par_err_nxt;
      frame_o_r   <= frame_o_nxt;
      frame_oe_r  <= frame_oe_nxt;
      req_o_r     <= req_o_nxt;
      req_oe_r    <= req_oe_nxt;
      cbe_o_r     <= cbe_o_nxt;
      cbe_oe_r    <= cbe_oe_nxt;
      ad_o_r      <= ad_o_nxt;
      ad_oe_r     <= ad_oe_nxt;
      par_o_r     <= par_o_nxt;
      par_oe_r    <= par_oe_nxt;
    end
  end

  // Peer monitor kept apart; its next value already folds reset
  always_ff @(posedge clk) begin
    peer_wide_r <= peer_wide_nxt;
  end

endmodule : sbx_dev_end

// file: design/sbx_tgt_end.sv
// Far-end target on the secondary bus 64-bit extension.
// Assumes one data phase per frame and the shared bus clock.
`timescale 1ns/1ps
`include "sbx_cfg.svh"
module sbx_tgt_end (
  input  wire logic        clk,
  input  wire logic        srst,
  sbx_bus_if.tgt           bus,
  input  wire logic        accept_wide,
  input  wire logic [31:0] rdata_hi,
  output logic             hit_r,
  output logic             wide_r,
  output logic [3:0]       cmd_r,
  output logic [31:0]      addr_hi_r,
  output logic [31:0]      wdata_hi_r,
  output logic [3:0]       wbe_hi_r,
  output logic             par_err_r
);

  sbx_pkg::sbx_tgt_t st_r;
  sbx_pkg::sbx_tgt_t st_nxt;
  logic [1:0]  cnt_r, cnt_nxt;
  logic        frm_q_r;
  logic        req_r, req_nxt;
  logic        hit_nxt, wide_nxt, par_err_nxt;
  logic [3:0]  cmd_nxt, wbe_nxt;
  logic [31:0] addr_nxt, wd_nxt;
  logic        dsel_o_r, dsel_o_nxt, dsel_oe_r, dsel_oe_nxt;
  logic        ack_o_r, ack_o_nxt, ack_oe_r, ack_oe_nxt;
  logic [31:0] ad_o_r, ad_o_nxt;
  logic        ad_oe_r, ad_oe_nxt, par_o_r, par_o_nxt, par_oe_r, par_oe_nxt;

  // Pins come straight from the output flops
  assign bus.t_devsel_o  = dsel_o_r;
  assign bus.t_devsel_oe = dsel_oe_r;
  assign bus.t_ack64_o   = ack_o_r;
  assign bus.t_ack64_oe  = ack_oe_r;
  assign bus.t_ad_o      = ad_o_r;
  assign bus.t_ad_oe     = ad_oe_r;
  assign bus.t_par_o     = par_o_r;
  assign bus.t_par_oe    = par_oe_r;

  // Target sequencer: decode, select, release
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    req_nxt     = req_r;
    hit_nxt     = 1'b0;
    wide_nxt    = wide_r;
    par_err_nxt = 1'b0;
    cmd_nxt     = cmd_r;
    addr_nxt    = addr_hi_r;
    wd_nxt      = wdata_hi_r;
    wbe_nxt     = wbe_hi_r;
    dsel_o_nxt  = dsel_o_r;
    dsel_oe_nxt = dsel_oe_r;
    ack_o_nxt   = ack_o_r;
    ack_oe_nxt  = ack_oe_r;
    ad_o_nxt    = ad_o_r;
    ad_oe_nxt   = ad_oe_r;
    par_o_nxt   = par_o_r;
    par_oe_nxt  = par_oe_r;
    unique case (st_r)
      sbx_pkg::SBX_T_IDLE: begin
        // Frame falling edge marks the address phase
        if (frm_q_r && !bus.frame_n) begin
          st_nxt   = sbx_pkg::SBX_T_DEC;
          cnt_nxt  = 2'h0;
          req_nxt  = ~bus.sec_wide_request_n;
          cmd_nxt  = bus.sec_upper_cmd_byte_en;
          addr_nxt = bus.ad_hi;
        end
      end
      sbx_pkg::SBX_T_DEC: begin
        cnt_nxt = cnt_r + 2'h1;
        // address parity checked one clock on
        if (cnt_r == 2'h0) begin
          par_err_nxt = req_r & (bus.sec_upper_parity !=
            sbx_pkg::sbx_par_even(addr_hi_r, cmd_r));
        end
        if (cnt_r == `SBX_TGT_DLY) begin
          st_nxt      = sbx_pkg::SBX_T_DATA;
          dsel_o_nxt  = 1'b0;
          dsel_oe_nxt = 1'b1;
          // wide ack on the select edge
          ack_o_nxt   = ~(req_r & accept_wide);
          ack_oe_nxt  = 1'b1;
          wide_nxt    = req_r & accept_wide;
          // upper read word only when wide agreed
          ad_o_nxt    = rdata_hi;
          ad_oe_nxt   = req_r & accept_wide & ~cmd_r[`SBX_CMD_WR_BIT];
        end
      end
      sbx_pkg::SBX_T_DATA: begin
        st_nxt  = sbx_pkg::SBX_T_REL;
        hit_nxt = 1'b1;
        // drive high one cycle before release
        dsel_o_nxt = 1'b1;
        ack_o_nxt  = 1'b1;
        ad_oe_nxt  = 1'b0;
        // upper enables qualify the wide write word
        if (wide_r && cmd_r[`SBX_CMD_WR_BIT]) begin
          wd_nxt  = bus.ad_hi;
          wbe_nxt = bus.sec_upper_cmd_byte_en;
        end
        // read data parity one clock after data
        par_o_nxt  = sbx_pkg::sbx_par_even(ad_o_r,
                                           bus.sec_upper_cmd_byte_en);
        par_oe_nxt = ad_oe_r;
      end
      sbx_pkg::SBX_T_REL: begin
        st_nxt      = sbx_pkg::SBX_T_IDLE;
        dsel_oe_nxt = 1'b0;
        ack_oe_nxt  = 1'b0;
        par_oe_nxt  = 1'b0;
        par_err_nxt = wide_r & cmd_r[`SBX_CMD_WR_BIT] &
          (bus.sec_upper_parity !=
           sbx_pkg::sbx_par_even(wdata_hi_r, wbe_hi_r));
      end
    endcase
  end

  // Registers; frame history resets high so no false start
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r       <= sbx_pkg::SBX_T_IDLE;
      cnt_r      <= 2'h0;
      frm_q_r    <= 1'b1;
      req_r      <= 1'b0;
      hit_r      <= 1'b0;
      wide_r     <= 1'b0;
      par_err_r  <= 1'b0;
      cmd_r      <= 4'h0;
      addr_hi_r  <= 32'h0000_0000;
      wdata_hi_r <= 32'h0000_0000;
      wbe_hi_r   <= 4'h0;
      dsel_o_r   <= 1'b1;
      dsel_oe_r  <= 1'b0;
      ack_o_r    <= 1'b1;
      ack_oe_r   <= 1'b0;
      ad_o_r     <= 32'h0000_0000;
      ad_oe_r    <= 1'b0;
      par_o_r    <= 1'b0;
      par_oe_r   <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      frm_q_r    <= bus.frame_n;
      req_r      <= req_nxt;
      hit_r      <= hit_nxt;
      wide_r     <= wide_nxt;
      par_err_r  <= par_err_nxt;
      cmd_r      <= cmd_nxt;
      addr_hi_r  <= addr_nxt;
      wdata_hi_r <= wd_nxt;
      wbe_hi_r   <= wbe_nxt;
      dsel_o_r   <= dsel_o_nxt;
      dsel_oe_r  <= dsel_oe_nxt;
      ack_o_r    <= ack_o_nxt;
      ack_oe_r   <= ack_oe_nxt;
      ad_o_r     <= ad_o_nxt;
      ad_oe_r    <= ad_oe_nxt;
      par_o_r    <= par_o_nxt;
      par_oe_r   <= par_oe_nxt;
    end
  end

endmodule : sbx_tgt_end

// file: verif/sbx_checker.sv
// Wire-level checks for one sbx_bus_if joining two design ends.
// Assumes the shared bus clock and its sync reset.
`timescale 1ns/1ps
module sbx_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        frame_n,
  input wire logic        sec_wide_request_n,
  input wire logic [3:0]  sec_upper_cmd_byte_en,
  input wire logic [31:0] ad_hi,
  input wire logic        sec_upper_parity,
  input wire logic        sec_target_select_n,
  input wire logic        sec_wide_ack_n,
  input wire logic        t_ack64_o,
  input wire logic        t_ack64_oe,
  input wire logic        m_req64_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ack_with_select: assert property (
    !sec_wide_ack_n |-> !sec_target_select_n) else $error("ack w/o select");
  // ack high one cycle, then off
  a_ack_high_release: assert property (
    t_ack64_oe && !t_ack64_o |=> (t_ack64_oe && t_ack64_o) ##1 !t_ack64_oe)
    else $error("ack release wrong");
  a_addr_parity: assert property (
    $fell(frame_n) && !sec_wide_request_n |=> sec_upper_parity ==
    ^{$past(ad_hi), $past(sec_upper_cmd_byte_en)})
    else $error("address parity wrong");
  a_data_parity: assert property (
    !sec_target_select_n && !sec_wide_ack_n |=> sec_upper_parity ==
    ^{$past(ad_hi), $past(sec_upper_cmd_byte_en)})
    else $error("data parity wrong");
  // request only while owning the bus
  a_req_in_frame: assert property (
    !sec_wide_request_n |-> !frame_n) else $error("request outside frame");
  a_select_window: assert property (
    $fell(frame_n) |-> ##[1:5] !sec_target_select_n)
    else $error("no select in window");
  a_ack_needs_req: assert property (
    $fell(sec_wide_ack_n) |-> $past(sec_wide_request_n, 3) == 1'b0)
    else $error("ack without request");
  a_reset_release: assert property (disable iff (1'b0)
    srst |=> !t_ack64_oe && !m_req64_oe) else $error("driven in reset");

  // Main scenarios reached
  c_wide: cover property (!sec_wide_ack_n);
  c_narrow: cover property (!sec_target_select_n && sec_wide_ack_n);
  c_req: cover property ($fell(frame_n) && !sec_wide_request_n);
endmodule : sbx_checker

// file: verif/testbench.sv
// Bench: bridge end against target end, and a second bridge end facing a
// scripted target. Assumes design files and sbx_cfg.svh compiled first.
`timescale 1ns/1ps
`include "sbx_cfg.svh"
module testbench;
  logic        clk = 1'b0, srst = 1'b1, start = 1'b0, start_b = 1'b0;
  logic        dac = 1'b0, wm = 1'b0, fw = 1'b0, acc = 1'b0;
  logic [3:0]  cmd = 4'h0, be = 4'h0, tcmd, twbe;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata = 32'h0, seed = 32'h5B98;
  logic [31:0] rd, rd_b, taddr, twdata;
  logic        busy, done, abort, wdone, pwide, hit, twide, tperr, perr_a;
  logic        busy_b, done_b, abort_b, wdone_b, perr_b;
  int          n_errors = 0, checks_done = 0, hits = 0, dn_a = 0, pe_a = 0;
  int          dn_b = 0, ab_b = 0, pe_b = 0, ab_a = 0;
  sbx_bus_if bus_a ();
  sbx_bus_if bus_b ();

  sbx_dev_end i_sbx_dev_end (.clk(clk), .srst(srst), .bus(bus_a),
    .start(start), .dac(dac), .wide_master(wm), .force_wide_transfer(fw),
    .cmd(cmd), .addr_hi(addr), .wdata_hi(wdata), .be_hi(be), .busy_r(busy),
    .done_r(done), .abort_r(abort), .wide_done_r(wdone), .rdata_hi_r(rd),
    .par_err_r(perr_a), .peer_wide_r(pwide));
  sbx_tgt_end i_sbx_tgt_end (.clk(clk), .srst(srst), .bus(bus_a),
    .accept_wide(acc), .rdata_hi(rdata), .hit_r(hit), .wide_r(twide),
    .cmd_r(tcmd), .addr_hi_r(taddr), .wdata_hi_r(twdata), .wbe_hi_r(twbe),
    .par_err_r(tperr));
  sbx_dev_end i_sbx_dev_end_b (.clk(clk), .srst(srst), .bus(bus_b),
    .start(start_b), .dac(dac), .wide_master(wm), .force_wide_transfer(fw),
    .cmd(cmd), .addr_hi(addr), .wdata_hi(wdata), .be_hi(be),
    .busy_r(busy_b), .done_r(done_b), .abort_r(abort_b),
    .wide_done_r(wdone_b), .rdata_hi_r(rd_b), .par_err_r(perr_b),
    .peer_wide_r());
  sbx_checker i_sbx_checker (.clk(clk), .srst(srst), .frame_n(bus_a.frame_n),
    .sec_wide_request_n(bus_a.sec_wide_request_n),
    .sec_upper_cmd_byte_en(bus_a.sec_upper_cmd_byte_en), .ad_hi(bus_a.ad_hi),
    .sec_upper_parity(bus_a.sec_upper_parity),
    .sec_target_select_n(bus_a.sec_target_select_n),
    .sec_wide_ack_n(bus_a.sec_wide_ack_n), .t_ack64_o(bus_a.t_ack64_o),
    .t_ack64_oe(bus_a.t_ack64_oe), .m_req64_oe(bus_a.m_req64_oe));

  // Free-running bus clock
  always #12.5 clk = ~clk;

  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge clk) begin
    hits <= hits + int'(hit);
    dn_a <= dn_a + int'(done);
    ab_a <= ab_a + int'(abort);
    pe_a <= pe_a + int'(perr_a) + int'(tperr);
    dn_b <= dn_b + int'(done_b);
    ab_b <= ab_b + int'(abort_b);
    pe_b <= pe_b + int'(perr_b);
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  // Waits out one transfer; bounded so a stuck end cannot hang us
  task automatic settle(input logic b);
    for (int i = 0; i < 12 && (b ? busy_b : busy) !== 1'b0; i++)
      @(negedge clk);
    @(negedge clk);
  endtask : settle

  // One transfer between the two design ends
  task automatic xfer(input logic d, w, f, a, input logic [3:0] c,
                      input logic [31:0] ad, wd, rv, input logic [3:0] b);
    logic        wide;
    logic [31:0] old;
    int          h0, d0, p0, a0;
    wide = (w | f) & a;
    old = rd;
    h0 = hits;
    d0 = dn_a;
    p0 = pe_a;
    a0 = ab_a;
    {dac, wm, fw, acc, cmd, addr, wdata, rdata, be} = {d, w, f, a, c, ad, wd,
                                                       rv, b};
    start = 1'b1;
    @(negedge clk) start = 1'b0;
    settle(1'b0);
    chk(dn_a - d0, 1, "done count");
    chk(ab_a - a0, 0, "no abort");
    chk(hits - h0, 1, "target hit count");
    chk(wdone, wide, "wide done");
    chk(twide, wide, "target wide");
    chk(pe_a - p0, 0, "parity error");
    if (d && (w | f)) chk(tcmd, c, "upper command");
    if (d && (w | f)) chk(taddr, ad, "upper address");
    if (wide && c[`SBX_CMD_WR_BIT]) chk(twdata, wd, "upper write");
    if (wide && c[`SBX_CMD_WR_BIT]) chk(twbe, b, "upper enables");
    if (!c[`SBX_CMD_WR_BIT]) chk(rd, wide ? rv : old, "upper read");
  endtask : xfer

  // Read by bridge end b against a scripted target; dly < 0 never selects
  task automatic far(input int dly, input logic ack, bad,
                     input logic [31:0] dv);
    logic [3:0]  cbe;
    logic [31:0] old;
    int          d0, a0, p0;
    old = rd_b;
    {d0, a0, p0} = {dn_b, ab_b, pe_b};
    {dac, wm, fw, cmd, be} = {1'b0, 1'b1, 1'b0, 4'h6, 4'hF};
    start_b = 1'b1;
    @(negedge clk) start_b = 1'b0;
    if (dly >= 0) begin
      repeat (dly) @(negedge clk);
      cbe = bus_b.sec_upper_cmd_byte_en;
      {bus_b.t_devsel_o, bus_b.t_ack64_o, bus_b.t_ad_o} = {1'b0, 1'b0, dv};
      {bus_b.t_devsel_oe, bus_b.t_ack64_oe, bus_b.t_ad_oe} = {1'b1, ack, 1'b1};
      @(negedge clk);
      {bus_b.t_devsel_o, bus_b.t_ack64_o, bus_b.t_ad_oe} = 3'h6;
      {bus_b.t_par_o, bus_b.t_par_oe} = {^{dv, cbe} ^ bad, 1'b1};
      @(negedge clk);
      {bus_b.t_devsel_oe, bus_b.t_ack64_oe, bus_b.t_par_oe} = 3'h0;
    end
    settle(1'b1);
    chk(dn_b - d0, dly >= 0, "far done");
    chk(ab_b - a0, dly < 0, "far abort");
    chk(wdone_b, ack && dly >= 0, "far wide");
    chk(rd_b, (ack && dly >= 0) ? dv : old, "far read");
    chk(pe_b - p0, ack && bad && dly >= 0, "far parity");
  endtask : far

  // Watchdog on the whole run
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {bus_b.t_ad_o, bus_b.t_ad_oe, bus_b.t_par_o, bus_b.t_par_oe} = 35'h0;
    {bus_b.t_devsel_o, bus_b.t_devsel_oe} = 2'h2;
    {bus_b.t_ack64_o, bus_b.t_ack64_oe} = 2'h2;
    repeat (20) @(negedge clk);
    chk(pwide, 1'b0, "peer wide in reset");
    srst = 1'b0;
    xfer(1, 1, 0, 1, 4'hB, 32'hFFFF_FFFF, 32'h8000_0001, 32'h0, 4'hF);
    xfer(1, 0, 1, 1, 4'h6, 32'h0, 32'h0, 32'hA5A5_5A5A, 4'h5);
    xfer(0, 0, 0, 1, 4'h6, 32'h1234_5678, 32'h0, 32'hDEAD_BEEF, 4'hF);
    xfer(1, 1, 0, 0, 4'h6, 32'h8000_0000, 32'h0, 32'h0F0F_0F0F, 4'h3);
    for (int i = 0; i < 16; i++) begin
      logic [31:0] r;
      r = rnd();
      xfer(r[0], r[1], r[2], r[3], r[7:4], rnd(), rnd(), rnd(), r[11:8]);
    end
    far(-1, 1'b1, 1'b0, 32'h0);
    far(3, 1'b0, 1'b1, 32'h5555_AAAA);
    far(2, 1'b1, 1'b1, 32'hC3C3_3C3C);
    far(3, 1'b1, 1'b0, rnd());
    tally_and_finish();
  end
endmodule : testbench
